// *** scisdi_pkg.sv ***
// shared constants and types of the serial status, data and interrupt block
package scisdi_pkg;
  // register indices, byte address is four times the index
  localparam logic [7:0] FLAGS1_IDX = 8'h74;
  localparam logic [7:0] FLAGS2_IDX = 8'h75;
  localparam logic [7:0] DATAHI_IDX = 8'h76;
  localparam logic [7:0] DATALO_IDX = 8'h77;
  localparam logic [7:0] CTRL_IDX = 8'h78;
  localparam logic [7:0] BAUD_IDX = 8'h79;
  // reset values
  localparam logic [7:0] FLAGS1_RST = 8'hc0;
  localparam logic [7:0] FLAGS2_RST = 8'h00;
  localparam logic [9:0] CTRL_RST = 10'h000;
  localparam logic [15:0] BAUD_RST = 16'h001a;
  // primary and secondary flag positions
  localparam int TX_BUFFER_EMPTY_FLAG_BIT = 7;
  localparam int TC_BIT = 6;
  localparam int RX_BUFFER_FULL_FLAG_BIT = 5;
  localparam int IDLE_BIT = 4;
  localparam int OVR_BIT = 3;
  localparam int NOISE_BIT = 2;
  localparam int FRAME_BIT = 1;
  localparam int PAR_BIT = 0;
  localparam int RAF_BIT = 0;
  // upper data register
  localparam int RXB9_BIT = 7;
  localparam int TXB9_BIT = 6;
  // control register positions
  localparam int TIE_BIT = 7;
  localparam int TX_DONE_IRQ_EN_BIT = 6;
  localparam int RIE_BIT = 5;
  localparam int QUIET_LINE_IRQ_EN_BIT = 4;
  localparam int TE_BIT = 3;
  localparam int RE_BIT = 2;
  localparam int RWU_BIT = 1;
  localparam int NINE_BIT = 0;
  localparam int PEN_BIT = 8;
  localparam int PODD_BIT = 9;
  // oversampling: ticks per bit and majority sample points
  localparam logic [3:0] TICK_LAST = 4'hf;
  localparam logic [3:0] SAMP_A = 4'h7;
  localparam logic [3:0] SAMP_C = 4'h9;
  localparam logic [3:0] FRAME8_BITS = 4'ha;
  localparam logic [3:0] FRAME9_BITS = 4'hb;
  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} scisdi_rx_t;
endpackage : scisdi_pkg

// *** scisdi_core.sv ***
// serial interface status flags, double-buffered data registers and interrupt request
// Summary of operation
// R1: buffer-empty flag set when transmit buffer empties
// R2: done flag set while transmitter idle
// R3: receive-full set when character reaches holding register
// R4: line-quiet only after activity then one idle character
// R5: wake-up control suppresses line-quiet flag
// R6: overrun keeps old character, discards new
// R7: noise flag on non-unanimous majority sample
// R8: framing flag on zero stop bit
// R9: parity flag on wrong received parity
// R10: noise, framing, parity never interrupt
// R11: secondary flags: only receiver-active bit zero
// R12: data reads receive buffer, writes transmit buffer
// R13: software writes upper before lower for nine bits
// R14: upper register: rx bit nine, tx bit nine
// R15: enabling transmitter sets empty and done flags
// R16: interrupt on empty flag with its enable
// R17: interrupt on done flag with its enable
// R18: disable finishes character, drops queue, releases pin
// R19: flags set when final character completes after disable
// R20: only reset aborts a transmit character in flight
// R21: only full, overrun, line-quiet interrupt on receive
// R22: receive interrupt on full or overrun
// R23: line-quiet interrupt with its enable
// R24: word-length select picks nine or eight data bits
// R25: all enabled conditions share one request output
`timescale 1ns/1ps
module scisdi_core
  import scisdi_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // axi4-lite write
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // serial pins
  input wire logic rxd,
  output logic txd,
  output logic txOwnsPin,
  // interrupt request
  output logic irq
);
  // the decode reads address bits from ten upward, so at least eleven are needed
  if (ADDR_W < 11) begin : g_addr_check
    $error("ADDR_W too small for register map");
  end

  function automatic logic major3(input logic [2:0] s);
    return (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction : major3

  function automatic logic parity9(input logic [8:0] d, input logic nine, input logic odd);
    return ^(nine ? d : {1'b0, d[7:0]}) ^ odd;
  endfunction : parity9

  logic [9:0] ctrl;
  logic [15:0] baud;
  logic [7:0] flags;
  logic [7:0] armed;
  logic [7:0] rxHold;
  logic rxBit9;
  logic txBit9;
  logic [8:0] txBuf;
  logic txBufValid;
  logic txBusy;
  logic teLast;

  // write channel holding
  logic [ADDR_W-1:0] wAddr;
  logic wAddrOk;
  logic [31:0] wData;
  logic [3:0] wStrb;
  logic wDataOk;
  logic doWrite;
  logic [7:0] wIdx;
  logic doRead;
  logic [7:0] rIdx;
  assign doWrite = wAddrOk & wDataOk & ~bvalid;
  assign wIdx = wAddr[9:2];
  assign doRead = arvalid & arready;
  assign rIdx = araddr[9:2];

  logic wrLow;
  logic wrHigh;
  logic rdFlags;
  logic rdLow;
  assign wrLow = doWrite & wStrb[0] & (wIdx == DATALO_IDX);
  assign wrHigh = doWrite & wStrb[0] & (wIdx == DATAHI_IDX);
  assign rdFlags = doRead & (rIdx == FLAGS1_IDX);
  assign rdLow = doRead & (rIdx == DATALO_IDX);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wAddrOk <= 1'b0;
      wDataOk <= 1'b0;
      wAddr <= '0;
      wData <= 32'h0;
      wStrb <= 4'h0;
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        wAddr <= awaddr;
        wAddrOk <= 1'b1;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        wData <= wdata;
        wStrb <= wstrb;
        wDataOk <= 1'b1;
        wready <= 1'b0;
      end
      if (doWrite) begin
        bvalid <= 1'b1;
        bresp <= (wIdx >= FLAGS1_IDX && wIdx <= BAUD_IDX && wAddr[ADDR_W-1:10] == '0)
                 ? RESP_OKAY : RESP_DECERR;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        wAddrOk <= 1'b0;
        wDataOk <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // software control registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= CTRL_RST;
      baud <= BAUD_RST;
      txBit9 <= 1'b0;
    end else if (doWrite) begin
      if (wIdx == CTRL_IDX) begin
        if (wStrb[0]) ctrl[7:0] <= wData[7:0];
        if (wStrb[1]) ctrl[9:8] <= wData[9:8];
      end
      if (wIdx == BAUD_IDX) begin
        if (wStrb[0]) baud[7:0] <= wData[7:0];
        if (wStrb[1]) baud[15:8] <= wData[15:8];
      end
      if (wrHigh) txBit9 <= wData[TXB9_BIT]; // [R13] [R14]
    end
  end

  // read channel
  logic [7:0] flags2;
  logic rxActive;
  assign flags2 = {7'h00, 1'b0} | {7'h00, rxActive}; // [R11]
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= RESP_OKAY;
    end else begin
      if (doRead) begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rresp <= RESP_OKAY;
        rdata <= 32'h0;
        if (araddr[ADDR_W-1:10] != '0) begin
          rresp <= RESP_DECERR;
        end else begin
          case (rIdx)
            FLAGS1_IDX: rdata[7:0] <= flags;
            FLAGS2_IDX: rdata[7:0] <= flags2; // [R11]
            DATAHI_IDX: rdata[7:0] <= {rxBit9, txBit9, 6'h00}; // [R14]
            DATALO_IDX: rdata[7:0] <= rxHold; // [R12]
            CTRL_IDX: rdata[9:0] <= ctrl;
            BAUD_IDX: rdata[15:0] <= baud;
            default: rresp <= RESP_DECERR;
          endcase
        end
      end
      if (rvalid && rready) begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  // oversample tick, sixteen per bit
  logic [15:0] divCnt;
  logic tick;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      divCnt <= 16'h0;
      tick <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (baud == 16'h0) begin
        divCnt <= 16'h0;
      end else if (divCnt >= baud - 16'h1) begin
        divCnt <= 16'h0;
        tick <= 1'b1;
      end else begin
        divCnt <= divCnt + 16'h1;
      end
    end
  end

  // transmitter
  logic [10:0] txShift;
  logic [3:0] txSub;
  logic [3:0] txBitNo;
  logic [3:0] txBits;
  logic txLoad;
  logic txFinish;
  logic [8:0] txWord;
  assign txBits = ctrl[NINE_BIT] ? FRAME9_BITS : FRAME8_BITS; // [R24]
  assign txLoad = ~txBusy & txBufValid & ctrl[TE_BIT];
  assign txFinish = txBusy & tick & (txSub == TICK_LAST) & (txBitNo == txBits - 4'h1);
  always_comb begin
    txWord = txBuf;
    if (ctrl[PEN_BIT] && ctrl[NINE_BIT]) begin
      txWord[8] = parity9({1'b0, txBuf[7:0]}, 1'b1, ctrl[PODD_BIT]);
    end else if (ctrl[PEN_BIT]) begin
      txWord[7] = parity9({2'b00, txBuf[6:0]}, 1'b0, ctrl[PODD_BIT]);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txBuf <= 9'h000;
      txBufValid <= 1'b0;
    end else begin
      if (wrLow && ctrl[TE_BIT]) begin
        txBuf <= {txBit9, wData[7:0]}; // [R12]
        txBufValid <= 1'b1;
      end else if (txLoad || !ctrl[TE_BIT]) begin
        txBufValid <= 1'b0; // [R18]
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txBusy <= 1'b0;
      txShift <= 11'h7ff;
      txSub <= 4'h0;
      txBitNo <= 4'h0;
      txd <= 1'b1;
    end else if (txLoad) begin
      txBusy <= 1'b1;
      txShift <= ctrl[NINE_BIT] ? {1'b1, txWord, 1'b0} : {2'b11, txWord[7:0], 1'b0};
      txSub <= 4'h0;
      txBitNo <= 4'h0;
      txd <= 1'b0;
    end else if (txBusy && tick) begin
      // a cleared enable never stops the frame here [R20]
      txSub <= txSub + 4'h1;
      if (txSub == TICK_LAST) begin
        txBitNo <= txBitNo + 4'h1;
        txShift <= {1'b1, txShift[10:1]};
        txd <= txShift[1];
        if (txFinish) begin
          txBusy <= 1'b0;
          txd <= 1'b1;
        end
      end
    end
  end

  // pin ownership returns on a tick once idle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txOwnsPin <= 1'b0;
      teLast <= 1'b0;
    end else begin
      teLast <= ctrl[TE_BIT];
      if (ctrl[TE_BIT]) txOwnsPin <= 1'b1;
      else if (!txBusy && tick) txOwnsPin <= 1'b0; // [R18]
    end
  end

  // receiver input synchroniser
  logic rxMeta;
  logic rxSync;
  logic rxPrev;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxMeta <= 1'b1;
      rxSync <= 1'b1;
      rxPrev <= 1'b1;
    end else begin
      rxMeta <= rxd;
      rxSync <= rxMeta;
      rxPrev <= rxSync;
    end
  end

  scisdi_rx_t rxState;
  logic [3:0] rxSub;
  logic [3:0] rxBitNo;
  logic [2:0] rxSamp;
  logic [8:0] rxShift;
  logic rxNoise;
  logic rxDone;
  logic rxBitVal;
  logic [3:0] rxDataBits;
  assign rxActive = (rxState != RX_IDLE); // [R11]
  assign rxBitVal = major3(rxSamp);
  assign rxDataBits = ctrl[NINE_BIT] ? 4'h9 : 4'h8; // [R24]
  assign rxDone = (rxState == RX_STOP) & tick & (rxSub == TICK_LAST);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxState <= RX_IDLE;
      rxSub <= 4'h0;
      rxBitNo <= 4'h0;
      rxSamp <= 3'h0;
      rxShift <= 9'h000;
      rxNoise <= 1'b0;
    end else if (!ctrl[RE_BIT]) begin
      rxState <= RX_IDLE;
    end else begin
      case (rxState)
        RX_IDLE: begin
          if (rxPrev && !rxSync) begin
            rxState <= RX_START;
            rxSub <= 4'h0;
            rxBitNo <= 4'h0;
            rxNoise <= 1'b0;
          end
        end
        default: begin
          if (tick) begin
            rxSub <= rxSub + 4'h1;
            if (rxSub >= SAMP_A && rxSub <= SAMP_C) rxSamp <= {rxSamp[1:0], rxSync};
            if (rxSub == TICK_LAST) begin
              if (rxSamp != 3'h0 && rxSamp != 3'h7) rxNoise <= 1'b1; // [R7]
              case (rxState)
                RX_START: rxState <= rxBitVal ? RX_IDLE : RX_DATA;
                RX_DATA: begin
                  rxShift <= ctrl[NINE_BIT] ? {rxBitVal, rxShift[8:1]}
                                            : {1'b0, rxBitVal, rxShift[7:1]};
                  rxBitNo <= rxBitNo + 4'h1;
                  if (rxBitNo == rxDataBits - 4'h1) rxState <= RX_STOP;
                end
                default: rxState <= RX_IDLE;
              endcase
            end
          end
        end
      endcase
    end
  end

  // quiet-line detection, counting ticks of a high line
  logic [7:0] quietCnt;
  logic lineActive;
  logic quietHit;
  logic [7:0] charTicks;
  assign charTicks = {txBits, 4'h0};
  assign quietHit = tick & rxSync & lineActive & (quietCnt == charTicks - 8'h1);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      quietCnt <= 8'h0;
      lineActive <= 1'b0;
    end else if (!rxSync) begin
      quietCnt <= 8'h0;
      lineActive <= 1'b1; // [R4]
    end else if (tick && lineActive) begin
      quietCnt <= quietCnt + 8'h1;
      if (quietHit) lineActive <= 1'b0; // [R4]
    end
  end

  // receive holding register, untouched on overrun
  logic frameFault;
  logic parFault;
  assign frameFault = ~rxBitVal;
  assign parFault = ctrl[PEN_BIT] & parity9(rxShift, ctrl[NINE_BIT], ctrl[PODD_BIT]);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxHold <= 8'h00;
      rxBit9 <= 1'b0;
    end else if (rxDone && !flags[RX_BUFFER_FULL_FLAG_BIT]) begin
      rxHold <= rxShift[7:0]; // [R6]
      rxBit9 <= rxShift[8]; // [R14]
    end
  end

  // clear sequence: a primary-flag read arms the bits seen set
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) armed <= 8'h00;
    else if (rdFlags) armed <= flags;
    else if (wrLow) armed[7:6] <= 2'b00;
    else if (rdLow) armed[5:0] <= 6'h00;
  end

  logic [7:0] setEv;
  logic [7:0] clrEv;
  logic newChar;
  logic teRise;
  assign newChar = rxDone & ~flags[RX_BUFFER_FULL_FLAG_BIT];
  assign teRise = ctrl[TE_BIT] & ~teLast;
  always_comb begin
    setEv = 8'h00;
    setEv[TX_BUFFER_EMPTY_FLAG_BIT] = txLoad | teRise | txFinish; // [R1] [R15] [R19]
    setEv[TC_BIT] = teRise | (txFinish & ~txBufValid) | (txFinish & ~ctrl[TE_BIT]); // [R2] [R19]
    setEv[RX_BUFFER_FULL_FLAG_BIT] = newChar; // [R3]
    setEv[IDLE_BIT] = quietHit & ~ctrl[RWU_BIT]; // [R4] [R5]
    setEv[OVR_BIT] = rxDone & flags[RX_BUFFER_FULL_FLAG_BIT]; // [R6]
    setEv[NOISE_BIT] = newChar & (rxNoise | (rxSamp != 3'h0 && rxSamp != 3'h7)); // [R7]
    setEv[FRAME_BIT] = newChar & frameFault; // [R8]
    setEv[PAR_BIT] = newChar & parFault; // [R9]
    clrEv = 8'h00;
    clrEv[7:6] = {2{wrLow}} & armed[7:6]; // [R1] [R2]
    clrEv[5:0] = {6{rdLow}} & armed[5:0]; // [R3] [R5] [R7] [R8] [R9]
  end

  // set wins over a coincident clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) flags <= FLAGS1_RST;
    else flags <= setEv | (flags & ~clrEv);
  end

  // noise, framing and parity flags are left out of the request [R10] [R21]
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) irq <= 1'b0;
    else irq <= (ctrl[TIE_BIT] & flags[TX_BUFFER_EMPTY_FLAG_BIT]) // [R16]
              | (ctrl[TX_DONE_IRQ_EN_BIT] & flags[TC_BIT]) // [R17]
              | (ctrl[RIE_BIT] & (flags[RX_BUFFER_FULL_FLAG_BIT] | flags[OVR_BIT])) // [R22]
              | (ctrl[QUIET_LINE_IRQ_EN_BIT] & flags[IDLE_BIT]); // [R23] [R25]
  end
endmodule : scisdi_core

// *** scisdi_props.sv ***
// assertion checker bound to the serial block ports
`timescale 1ns/1ps
module scisdi_props
  import scisdi_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register bus
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  // serial pin
  input wire logic txd,
  input wire logic txOwnsPin
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence arTake(a);
    arvalid && arready && araddr == a;
  endsequence
  sequence wrTake;
    awvalid && awready && wvalid && wready;
  endsequence
  AST_READ_ANSWER: assert property (arvalid && arready |=> rvalid)
    else $error("read not answered in time");
  AST_WRITE_ANSWER: assert property (wrTake |=> ##[0:1] bvalid)
    else $error("write not answered in time");
  AST_FLAGS2_ZERO: assert property (arTake(12'h1d4) |=> rdata[31:1] == '0)
    else $error("secondary flags unused bits not zero");
  AST_DATAHI_ZERO: assert property (arTake(12'h1d8) |=> rdata[5:0] == '0)
    else $error("upper data low bits not zero");
  AST_UNMAPPED: assert property (arvalid && arready && araddr[ADDR_W-1:10] != '0
    |=> rresp == RESP_DECERR && rdata == '0)
    else $error("unmapped read not refused");
  AST_TX_OWNED: assert property (!txd |-> txOwnsPin)
    else $error("line low while pin released");
  AST_BIT_SPAN: assert property ($fell(txd) |-> !txd [*8])
    else $error("low bit cut short");
  AST_RELEASE_IDLE: assert property ($fell(txOwnsPin) |-> txd && $past(txd))
    else $error("pin released mid character");
endmodule : scisdi_props

bind scisdi_core scisdi_props #(.ADDR_W(ADDR_W)) u_props (
  .clk(clk),
  .rst_n(rst_n),
  .awvalid(awvalid),
  .awready(awready),
  .wvalid(wvalid),
  .wready(wready),
  .bvalid(bvalid),
  .araddr(araddr),
  .arvalid(arvalid),
  .arready(arready),
  .rdata(rdata),
  .rresp(rresp),
  .rvalid(rvalid),
  .txd(txd),
  .txOwnsPin(txOwnsPin)
);

// *** scisdi_remote_uart.sv ***
// behavioural far-end serial transceiver
`timescale 1ns/1ps
module scisdi_remote_uart #(
  parameter int BIT_CYC = 16
) (
  // clock
  input wire logic clk,
  // serial lines
  output logic rxd,
  input wire logic txd
);
  logic nineMode = 1'b0;
  logic [8:0] got[$];
  // an idle line rests high between frames
  initial rxd = 1'b1;
  task automatic send(input logic [8:0] d, input int n, input logic stopBit);
    for (int i = 0; i < n + 2; i++) begin
      @(posedge clk);
      rxd <= (i == 0) ? 1'b0 : (i > n) ? stopBit : d[i-1];
      repeat (BIT_CYC - 1) @(posedge clk);
    end
    @(posedge clk);
    rxd <= 1'b1;
  endtask : send
  // samples each bit near its middle
  always begin : capture
    logic [8:0] f;
    @(negedge txd);
    f = '0;
    repeat (BIT_CYC / 2) @(posedge clk);
    for (int i = 0; i < (nineMode ? 9 : 8); i++) begin
      repeat (BIT_CYC) @(posedge clk);
      f[i] = txd;
    end
    repeat (BIT_CYC) @(posedge clk);
    got.push_back(f);
  end
endmodule : scisdi_remote_uart

// *** sci_status_data_interrupts_test.sv ***
// self-checking bench for the serial status, data and interrupt block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin numChecks++; if ((g) !== (e)) begin failures++; \
  $display("unexpected %s expected %h seen %h", nm, e, g); end end
module sci_status_data_interrupts_test
  import scisdi_pkg::*;
;
  localparam logic [11:0] A_F1 = {2'b00, FLAGS1_IDX, 2'b00};
  localparam logic [11:0] A_F2 = {2'b00, FLAGS2_IDX, 2'b00};
  localparam logic [11:0] A_HI = {2'b00, DATAHI_IDX, 2'b00};
  localparam logic [11:0] A_LO = {2'b00, DATALO_IDX, 2'b00};
  localparam logic [11:0] A_CT = {2'b00, CTRL_IDX, 2'b00};
  localparam logic [11:0] A_BD = {2'b00, BAUD_IDX, 2'b00};
  logic clk = 1'b0, rst_n = 1'b0;
  logic [11:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  // answers are always accepted at once
  logic bready = 1'b1, rready = 1'b1;
  logic awready, wready, bvalid, arready, rvalid, rxd, txd, txOwnsPin, irq;
  logic [1:0] bresp, rresp, resp;
  int failures = 0, numChecks = 0;
  always #10 clk = ~clk;
  scisdi_core dut (.clk, .rst_n, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .rxd, .txd, .txOwnsPin, .irq);
  scisdi_remote_uart #(.BIT_CYC(16)) u_far (.clk, .rxd, .txd);
  task automatic final_report;
    if (failures == 0 && numChecks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : final_report
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (awvalid && awready !== 1'b1 || wvalid && wready !== 1'b1);
    do @(posedge clk); while (bvalid !== 1'b1);
    resp = bresp;
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    d = rdata;
    resp = rresp;
  endtask : rd
  task automatic peek(input logic [11:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [31:0] d;
    rd(a, d);
    `CHK($sformatf("reg %h", a), e, d[7:0] & m)
  endtask : peek
  // waits out any pending quiet-line detection, then clears all receive flags
  task automatic settle;
    logic [31:0] d;
    repeat (200) @(posedge clk);
    rd(A_F1, d);
    rd(A_LO, d);
  endtask : settle
  task automatic testReset;
    logic [31:0] d;
    peek(A_F1, 8'hff, FLAGS1_RST);
    peek(A_F2, 8'hff, FLAGS2_RST);
    rd(12'h800, d);
    `CHK("unmapped resp", RESP_DECERR, resp)
    wr(12'h800, 32'h0);
    `CHK("unmapped write resp", RESP_DECERR, resp)
    wr(A_BD, 32'h1);
    `CHK("write resp", RESP_OKAY, resp)
  endtask : testReset
  task automatic testTx;
    wr(A_BD, 32'h1);
    wr(A_CT, 32'h88);
    repeat (2) @(posedge clk);
    `CHK("irq", 1'b1, irq)
    peek(A_F1, 8'hff, 8'hc0);
    wr(A_LO, 32'h5a);
    peek(A_F1, 8'hc0, 8'h80);
    wr(A_LO, 32'hc3);
    peek(A_F1, 8'hc0, 8'h00);
    `CHK("irq", 1'b0, irq)
    repeat (400) @(posedge clk);
    `CHK("tx count", 2, u_far.got.size())
    `CHK("tx first", 9'h05a, u_far.got[0])
    `CHK("tx second", 9'h0c3, u_far.got[1])
    peek(A_F1, 8'hc0, 8'hc0);
    wr(A_CT, 32'h48);
    repeat (2) @(posedge clk);
    `CHK("irq", 1'b1, irq)
  endtask : testTx
  task automatic testDisable;
    wr(A_CT, 32'h08);
    peek(A_F1, 8'hc0, 8'hc0);
    wr(A_LO, 32'hff);
    wr(A_LO, 32'h00);
    wr(A_CT, 32'h00);
    `CHK("tx pin", 1'b1, txOwnsPin)
    repeat (400) @(posedge clk);
    `CHK("tx count", 3, u_far.got.size())
    `CHK("tx last", 9'h0ff, u_far.got[2])
    peek(A_F1, 8'hc0, 8'hc0);
    `CHK("tx pin", 1'b0, txOwnsPin)
  endtask : testDisable
  task automatic testNine;
    wr(A_CT, 32'h0d);
    u_far.nineMode = 1'b1;
    wr(A_HI, 32'h40);
    wr(A_LO, 32'h12);
    repeat (250) @(posedge clk);
    `CHK("tx nine", 9'h112, u_far.got[3])
    u_far.send(9'h1a5, 9, 1'b1);
    repeat (20) @(posedge clk);
    peek(A_F1, 8'h3f, 8'h20);
    peek(A_HI, 8'hff, 8'hc0);
    peek(A_LO, 8'hff, 8'ha5);
    u_far.nineMode = 1'b0;
  endtask : testNine
  task automatic testRx;
    logic [31:0] d;
    wr(A_CT, 32'h34);
    settle;
    u_far.send(9'h03c, 8, 1'b1);
    repeat (20) @(posedge clk);
    `CHK("irq", 1'b1, irq)
    peek(A_F1, 8'h3f, 8'h20);
    peek(A_LO, 8'hff, 8'h3c);
    peek(A_F1, 8'h3f, 8'h00);
    repeat (200) @(posedge clk);
    peek(A_F1, 8'h3f, 8'h10);
    `CHK("irq", 1'b1, irq)
    rd(A_LO, d);
    repeat (400) @(posedge clk);
    peek(A_F1, 8'h3f, 8'h00);
    `CHK("irq", 1'b0, irq)
  endtask : testRx
  task automatic testOverrun;
    settle;
    u_far.send(9'h011, 8, 1'b1);
    u_far.send(9'h022, 8, 1'b1);
    repeat (20) @(posedge clk);
    peek(A_F1, 8'h3f, 8'h28);
    `CHK("irq", 1'b1, irq)
    peek(A_LO, 8'hff, 8'h11);
  endtask : testOverrun
  task automatic testFaults;
    logic [31:0] d;
    wr(A_CT, 32'h14);
    settle;
    u_far.send(9'h055, 8, 1'b0);
    repeat (20) @(posedge clk);
    `CHK("irq", 1'b0, irq)
    peek(A_F1, 8'h3f, 8'h22);
    rd(A_LO, d);
    // parity on: top data bit carries even parity, sent wrong on purpose
    wr(A_CT, 32'h104);
    settle;
    u_far.send(9'h001, 8, 1'b1);
    repeat (20) @(posedge clk);
    peek(A_F1, 8'h3f, 8'h21);
  endtask : testFaults
  task automatic testWakeup;
    wr(A_CT, 32'h16);
    settle;
    u_far.send(9'h03c, 8, 1'b1);
    repeat (220) @(posedge clk);
    peek(A_F1, 8'h10, 8'h00);
    `CHK("irq", 1'b0, irq)
  endtask : testWakeup
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    testReset;
    testTx;
    testDisable;
    testNine;
    testRx;
    testOverrun;
    testFaults;
    testWakeup;
    final_report;
  end
  initial begin
    repeat (30000) @(posedge clk);
    failures++;
    final_report;
  end
endmodule : sci_status_data_interrupts_test
